/* File: hdl/rfs_pkg.sv */
package rfs_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] RFS_OVS_OFS = 8'h54;
	localparam logic [7:0] RFS_UNS_OFS = 8'h58;
	localparam logic [7:0] RFS_RXC_OFS = 8'h5C;
	localparam logic [7:0] RFS_STS_OFS = 8'h60;
	localparam logic [7:0] RFS_MSK_OFS = 8'h64;
	localparam logic [31:0] RFS_OVS_RST = 32'h0;
	localparam logic [31:0] RFS_UNS_RST = 32'h0;
	localparam logic [31:0] RFS_RXC_RST = 32'h0;
	localparam logic [31:0] RFS_OVS_MASK = 32'hFFFF001F;
	localparam logic [31:0] RFS_UNS_MASK = 32'hFFFF003F;
	localparam logic [31:0] RFS_RXC_MASK = 32'hFFE00000;
	// ****************************************
	// field positions
	// ****************************************
	localparam int RFS_PAT_MSB = 31;
	localparam int RFS_PAT_LSB = 16;
	localparam int RFS_LEN_MSB = 4;
	localparam int RFS_LEN_LSB = 1;
	localparam int RFS_ON_BIT = 0;
	localparam int RFS_FINAL_BIT = 5;
	localparam int RFS_ALT_BIT = 31;
	localparam int RFS_ABSENT_BIT = 30;
	localparam int RFS_EXT_BIT = 29;
	localparam int RFS_PFD_BIT = 28;
	localparam int RFS_MODE_MSB = 27;
	localparam int RFS_MODE_LSB = 25;
	localparam int RFS_COLL_BIT = 24;
	localparam int RFS_POLICY_BIT = 23;
	localparam int RFS_KEEP_BIT = 22;
	localparam int RFS_CRCWR_BIT = 21;
	localparam logic [2:0] RFS_BYTE3_IDX = 3'h2;
	localparam logic [2:0] RFS_BYTE4_IDX = 3'h3;
	// ****************************************
	// status bits
	// ****************************************
	localparam int RFS_STS_W = 5;
	localparam int RFS_STS_EMD = 0;
	localparam int RFS_STS_PAR = 1;
	localparam int RFS_STS_INTEG = 2;
	localparam int RFS_STS_STORED = 3;
	localparam int RFS_STS_DROPPED = 4;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		RFS_MODE_OFF = 3'h0,
		RFS_MODE_ISO = 3'h1,
		RFS_MODE_NFC3 = 3'h2,
		RFS_MODE_NFC4 = 3'h3,
		RFS_MODE_NFC4_SHORT = 3'h4
	} rfs_mode_type;
	typedef struct packed {
		logic active;
		logic bit_val;
		logic [3:0] left;
		logic [3:0] idx;
	} rfs_shp_type;
	typedef struct packed {
		logic bit_valid;
		logic bit_val;
		logic collision;
		logic parity_err;
		logic parity_absent;
		logic byte_done;
		logic [2:0] byte_idx;
		logic crc_byte;
		logic crc_en;
		logic frame_end;
		logic frame_short;
		logic frame_lt4;
	} rfs_rx_in_type;
	typedef struct packed {
		logic bit_valid;
		logic bit_val;
		logic store;
		logic drop;
		logic emd_err;
		logic parity_err;
		logic integrity_err;
	} rfs_rx_out_type;
endpackage

/* File: hdl/rfs_shaper.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - overshoot on: send the 16-bit overshoot pattern after each envelope rise
// - overshoot length field gives value plus one bits, taken from pattern MSB
// - overshoot enable bit zero clear means no overshoot pattern
// - undershoot on: send the 16-bit undershoot pattern after each envelope rise
// - undershoot length field gives value plus one bits, from MSB downward
// - undershoot enable bit zero guards every rising edge
// - bit five, with bit zero clear, limits undershoot guard to final card-mode subcarrier cycle
// - suppression field picks off, iso, three-char, four-char, four-char ignoring short
// - bit 28 turns third/fourth byte parity errors into disturbance errors
// - bit 29 enables the extended disturbance options
// - bit 30 treats missing fourth-byte parity as disturbance in modes three, four
// - bit 31 defers the parity disturbance decision to byte end
// - bit 24 reports any collision as integrity error
// - bit 23 zero clears bits after collision, one keeps them
// - bit 22 keeps sub-byte frames when crc is on, else dropped
// - bit 21 writes crc bytes to ram, else strips them
module rfs_shaper (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic tx_env_in,
	input wire logic tx_last_sc_in,
	output rfs_pkg::rfs_shp_type boost_out,
	output rfs_pkg::rfs_shp_type dip_out,
	input wire rfs_pkg::rfs_rx_in_type rx_in,
	output rfs_pkg::rfs_rx_out_type rx_out,
	output logic irq_out
);
	import rfs_pkg::*;

	typedef struct packed {
		logic [31:0] ovs;
		logic [31:0] uns;
		logic [31:0] rxc;
		logic [RFS_STS_W-1:0] sts;
		logic [RFS_STS_W-1:0] msk;
		logic [31:0] rdata;
		logic env_d;
		logic coll_seen;
		logic par_pend;
		logic frame_bad;
		rfs_shp_type boost;
		rfs_shp_type dip;
		rfs_rx_out_type rx;
	} rfs_state_type;

	rfs_state_type s_r;
	rfs_state_type s_nxt;

	// ****************************************
	// pattern shaper step
	// ****************************************
	function automatic rfs_shp_type rfs_shape(input rfs_shp_type cur, input logic trig,
		input logic [15:0] pat, input logic [3:0] len);
		rfs_shp_type r;
		r = cur;
		if (trig) begin
			r.active = 1'b1;
			r.bit_val = pat[15];
			r.left = len;
			r.idx = 4'h1;
		end else if (cur.left != 4'h0) begin
			r.active = 1'b1;
			r.bit_val = pat[4'hF - cur.idx];
			r.left = cur.left - 4'h1;
			r.idx = cur.idx + 4'h1;
		end else begin
			r.active = 1'b0;
			r.bit_val = 1'b0;
			r.idx = 4'h0;
		end
		return r;
	endfunction

	logic setup;
	logic access;
	logic hit;
	logic rise;
	logic boost_on;
	logic dip_on;
	logic dip_final;
	logic boost_trig;
	logic dip_trig;
	rfs_mode_type mode;
	logic ext;
	logic alt;
	logic nfc4;
	logic emd_byte;
	logic par_hit;
	logic par_judge;
	logic absent_evt;
	logic emd_evt;
	logic par_evt;
	logic integ_evt;
	logic short_drop;
	logic lt4_drop;
	logic [RFS_STS_W-1:0] ev;
	logic [RFS_STS_W-1:0] clr;

	always_comb begin
		setup = psel_in & ~penable_in;
		access = psel_in & penable_in;
		hit = (paddr_in == RFS_OVS_OFS) | (paddr_in == RFS_UNS_OFS) | (paddr_in == RFS_RXC_OFS)
			| (paddr_in == RFS_STS_OFS) | (paddr_in == RFS_MSK_OFS);
		rise = tx_env_in & ~s_r.env_d;
		boost_on = s_r.ovs[RFS_ON_BIT];
		dip_on = s_r.uns[RFS_ON_BIT];
		dip_final = s_r.uns[RFS_FINAL_BIT];
		boost_trig = rise & boost_on;
		// final-cycle mode is only honoured with the general enable clear
		dip_trig = rise & (dip_on | (dip_final & ~dip_on & tx_last_sc_in));
		mode = rfs_mode_type'(s_r.rxc[RFS_MODE_MSB:RFS_MODE_LSB]);
		ext = s_r.rxc[RFS_EXT_BIT];
		alt = ext & s_r.rxc[RFS_ALT_BIT];
		nfc4 = (mode == RFS_MODE_NFC4) | (mode == RFS_MODE_NFC4_SHORT);
		emd_byte = ((mode == RFS_MODE_NFC3) & (rx_in.byte_idx == RFS_BYTE3_IDX))
			| (nfc4 & (rx_in.byte_idx == RFS_BYTE4_IDX));
		par_hit = s_r.rxc[RFS_PFD_BIT] & emd_byte;
		par_judge = alt ? (rx_in.byte_done & (s_r.par_pend | rx_in.parity_err)) : rx_in.parity_err;
		absent_evt = ext & s_r.rxc[RFS_ABSENT_BIT] & nfc4 & rx_in.parity_absent
			& (rx_in.byte_idx == RFS_BYTE4_IDX);
		emd_evt = (par_judge & par_hit) | absent_evt;
		par_evt = par_judge & ~par_hit;
		integ_evt = rx_in.collision & s_r.rxc[RFS_COLL_BIT];
		short_drop = rx_in.frame_short & rx_in.crc_en & ~s_r.rxc[RFS_KEEP_BIT];
		lt4_drop = (mode == RFS_MODE_NFC4_SHORT) & rx_in.frame_lt4 & ~s_r.frame_bad;
		clr = '0;
		s_nxt = s_r;
		// ****************************************
		// apb register file
		// ****************************************
		if (setup) begin
			unique case (paddr_in)
				RFS_OVS_OFS: s_nxt.rdata = s_r.ovs;
				RFS_UNS_OFS: s_nxt.rdata = s_r.uns;
				RFS_RXC_OFS: s_nxt.rdata = s_r.rxc;
				RFS_STS_OFS: s_nxt.rdata = 32'(s_r.sts);
				RFS_MSK_OFS: s_nxt.rdata = 32'(s_r.msk);
				default: s_nxt.rdata = 32'h0;
			endcase
		end
		if (access & pwrite_in) begin
			unique case (paddr_in)
				RFS_OVS_OFS: s_nxt.ovs = pwdata_in & RFS_OVS_MASK;
				RFS_UNS_OFS: s_nxt.uns = pwdata_in & RFS_UNS_MASK;
				RFS_RXC_OFS: s_nxt.rxc = pwdata_in & RFS_RXC_MASK;
				RFS_STS_OFS: clr = pwdata_in[RFS_STS_W-1:0];
				RFS_MSK_OFS: s_nxt.msk = pwdata_in[RFS_STS_W-1:0];
				default: clr = '0;
			endcase
		end
		// ****************************************
		// transmit shaping
		// ****************************************
		s_nxt.env_d = tx_env_in;
		s_nxt.boost = rfs_shape(s_r.boost, boost_trig, s_r.ovs[RFS_PAT_MSB:RFS_PAT_LSB],
			s_r.ovs[RFS_LEN_MSB:RFS_LEN_LSB]);
		s_nxt.dip = rfs_shape(s_r.dip, dip_trig, s_r.uns[RFS_PAT_MSB:RFS_PAT_LSB],
			s_r.uns[RFS_LEN_MSB:RFS_LEN_LSB]);
		// ****************************************
		// receive framing
		// ****************************************
		s_nxt.rx.bit_valid = rx_in.bit_valid & ~(rx_in.crc_byte & ~s_r.rxc[RFS_CRCWR_BIT]);
		s_nxt.rx.bit_val = rx_in.bit_val & (s_r.rxc[RFS_POLICY_BIT] | ~s_r.coll_seen);
		s_nxt.rx.emd_err = emd_evt & (mode != RFS_MODE_OFF);
		s_nxt.rx.parity_err = par_evt | (emd_evt & (mode == RFS_MODE_OFF));
		s_nxt.rx.integrity_err = integ_evt;
		s_nxt.rx.drop = rx_in.frame_end & (short_drop | lt4_drop);
		s_nxt.rx.store = rx_in.frame_end & ~(short_drop | lt4_drop);
		if (rx_in.frame_end) begin
			s_nxt.coll_seen = 1'b0;
			s_nxt.frame_bad = 1'b0;
			s_nxt.par_pend = 1'b0;
		end else begin
			s_nxt.coll_seen = s_r.coll_seen | rx_in.collision;
			s_nxt.frame_bad = s_r.frame_bad | rx_in.parity_err | rx_in.collision | rx_in.parity_absent;
			s_nxt.par_pend = alt & ~rx_in.byte_done & (s_r.par_pend | rx_in.parity_err);
		end
		// ****************************************
		// interrupt status, set wins over clear
		// ****************************************
		ev = '0;
		ev[RFS_STS_EMD] = s_nxt.rx.emd_err;
		ev[RFS_STS_PAR] = s_nxt.rx.parity_err;
		ev[RFS_STS_INTEG] = integ_evt;
		ev[RFS_STS_STORED] = s_nxt.rx.store;
		ev[RFS_STS_DROPPED] = s_nxt.rx.drop;
		s_nxt.sts = (s_r.sts & ~clr) | ev;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= '0;
			s_r.ovs <= RFS_OVS_RST;
			s_r.uns <= RFS_UNS_RST;
			s_r.rxc <= RFS_RXC_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata_out = s_r.rdata;
	assign pready_out = 1'b1;
	assign pslverr_out = access & ~hit;
	assign boost_out = s_r.boost;
	assign dip_out = s_r.dip;
	assign rx_out = s_r.rx;
	assign irq_out = |(s_r.sts & s_r.msk);

	// ****************************************
	// assertions
	// ****************************************
	sequence rfs_boost_one_bit;
		boost_trig && (s_r.ovs[RFS_LEN_MSB:RFS_LEN_LSB] == 4'h0) ##1 !boost_trig;
	endsequence

	a_boost_first_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		boost_trig |=> boost_out.active && (boost_out.bit_val == $past(s_r.ovs[RFS_PAT_MSB])))
		else $error("overshoot pattern did not start at its msb");

	a_boost_length_one: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rfs_boost_one_bit |=> !boost_out.active)
		else $error("overshoot pattern ran past one bit");

	a_boost_disabled: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!boost_on && (s_r.boost.left == 4'h0) |=> !boost_out.active)
		else $error("overshoot pattern sent while disabled");

	a_dip_final_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rise && !dip_on && dip_final && !tx_last_sc_in && (s_r.dip.left == 4'h0)
		|=> !dip_out.active)
		else $error("undershoot guard outside final subcarrier cycle");

	a_dip_every_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rise && dip_on |=> dip_out.active && (dip_out.idx == 4'h1))
		else $error("undershoot guard missed a rising edge");

	a_parity_to_emd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.parity_err && !alt && par_hit && (mode != RFS_MODE_OFF) |=> rx_out.emd_err && !rx_out.parity_err)
		else $error("parity error not classed as disturbance");

	a_coll_zeroing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.bit_valid && s_r.coll_seen && !s_r.rxc[RFS_POLICY_BIT] |=> !rx_out.bit_val)
		else $error("bit after collision not cleared");

	a_coll_integrity: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.collision && s_r.rxc[RFS_COLL_BIT] |=> rx_out.integrity_err ##1 irq_out || !s_r.msk[RFS_STS_INTEG])
		else $error("collision not reported as integrity error");

	a_short_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.frame_end && short_drop |=> rx_out.drop && !rx_out.store)
		else $error("short frame stored with keep bit clear");

	a_crc_strip: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.bit_valid && rx_in.crc_byte && !s_r.rxc[RFS_CRCWR_BIT] |=> !rx_out.bit_valid)
		else $error("crc bit passed while stripping");

	a_resv_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		setup && (paddr_in == RFS_OVS_OFS) |=> prdata_out[15:5] == 11'h0)
		else $error("reserved overshoot bits read nonzero");

	// parity error held over idle cycles until the byte closes
	sequence rfs_alt_pending;
		alt && rx_in.parity_err && !rx_in.byte_done && !rx_in.frame_end
		##1 (alt && !rx_in.byte_done && !rx_in.frame_end)[*2] ##1 alt && rx_in.byte_done;
	endsequence

	a_boost_len_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		boost_trig |=> boost_out.left == $past(s_r.ovs[RFS_LEN_MSB:RFS_LEN_LSB]))
		else $error("overshoot length not loaded");

	a_boost_count_down: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(boost_out.left != 4'h0) && !boost_trig |=> boost_out.active && (boost_out.left == $past(boost_out.left) - 4'h1))
		else $error("overshoot pattern did not count down");

	a_boost_stops: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		boost_out.active && (boost_out.left == 4'h0) && !boost_trig |=> !boost_out.active)
		else $error("overshoot pattern ran too long");

	a_boost_idx_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(boost_out.left != 4'h0) && !boost_trig |=> boost_out.idx == $past(boost_out.idx) + 4'h1)
		else $error("overshoot pattern skipped a bit");

	a_boost_idle_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!boost_out.active |-> !boost_out.bit_val && (boost_out.left == 4'h0))
		else $error("overshoot stream not quiet while idle");

	a_dip_len_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		dip_trig |=> dip_out.left == $past(s_r.uns[RFS_LEN_MSB:RFS_LEN_LSB]))
		else $error("undershoot length not loaded");

	a_dip_count_down: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(dip_out.left != 4'h0) && !dip_trig |=> dip_out.active && (dip_out.left == $past(dip_out.left) - 4'h1))
		else $error("undershoot pattern did not count down");

	a_dip_stops: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		dip_out.active && (dip_out.left == 4'h0) && !dip_trig |=> !dip_out.active)
		else $error("undershoot pattern ran too long");

	a_dip_idx_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(dip_out.left != 4'h0) && !dip_trig |=> dip_out.idx == $past(dip_out.idx) + 4'h1)
		else $error("undershoot pattern skipped a bit");

	a_dip_first_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		dip_trig |=> dip_out.active && (dip_out.bit_val == $past(s_r.uns[RFS_PAT_MSB])))
		else $error("undershoot pattern did not start at its msb");

	a_dip_final_fire: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rise && !dip_on && dip_final && tx_last_sc_in |=> dip_out.active && (dip_out.idx == 4'h1))
		else $error("undershoot guard missed final subcarrier cycle");

	a_dip_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rise && !dip_on && !dip_final && (s_r.dip.left == 4'h0) |=> !dip_out.active)
		else $error("undershoot guard sent while disabled");

	a_parity_plain: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.parity_err && !alt && !par_hit |=> rx_out.parity_err)
		else $error("parity error not reported");

	a_absent_emd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		absent_evt |=> rx_out.emd_err)
		else $error("absent parity not classed as disturbance");

	a_absent_basic: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.parity_absent && !ext && !rx_in.parity_err |=> !rx_out.emd_err)
		else $error("extended option acted while disabled");

	a_alt_defer: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		alt && rx_in.parity_err && !rx_in.byte_done |=> !rx_out.parity_err)
		else $error("parity judged before byte end");

	a_alt_judged: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rfs_alt_pending |=> rx_out.parity_err || rx_out.emd_err)
		else $error("deferred parity error lost");

	a_coll_keep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.bit_valid && s_r.rxc[RFS_POLICY_BIT] |=> rx_out.bit_val == $past(rx_in.bit_val))
		else $error("bit value not kept");

	a_no_coll_integ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!rx_in.collision |=> !rx_out.integrity_err)
		else $error("integrity error without collision");

	a_short_keep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.frame_end && rx_in.frame_short && rx_in.crc_en && s_r.rxc[RFS_KEEP_BIT]
		&& (mode != RFS_MODE_NFC4_SHORT) |=> rx_out.store)
		else $error("short frame dropped with keep bit set");

	a_crc_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.bit_valid && s_r.rxc[RFS_CRCWR_BIT] |=> rx_out.bit_valid)
		else $error("crc bit stripped while writing");

	a_lt4_ignore: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.frame_end && (mode == RFS_MODE_NFC4_SHORT) && rx_in.frame_lt4 && !s_r.frame_bad
		|=> rx_out.drop && !rx_out.store)
		else $error("valid short frame not ignored");

	a_store_or_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_in.frame_end |=> rx_out.store != rx_out.drop)
		else $error("frame neither or both stored and dropped");

	a_resv_uns: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		setup && (paddr_in == RFS_UNS_OFS) |=> (prdata_out & ~RFS_UNS_MASK) == 32'h0)
		else $error("reserved undershoot bits read nonzero");

	a_resv_rxc: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		setup && (paddr_in == RFS_RXC_OFS) |=> (prdata_out & ~RFS_RXC_MASK) == 32'h0)
		else $error("reserved receive bits read nonzero");
endmodule
`default_nettype wire

/* File: hdl/rfs_dummy_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: tb/rfs_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// card side: receive events as pulses
// ****************************************
module rfs_card_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic send_in,
	input wire rfs_pkg::rfs_rx_in_type event_in,
	output rfs_pkg::rfs_rx_in_type rx_out
);
	import rfs_pkg::*;
	// each requested event stands for exactly one cycle, idle otherwise
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_out <= '0;
		end else if (send_in) begin
			rx_out <= event_in;
		end else begin
			rx_out <= '0;
		end
	end
endmodule
`default_nettype wire

/* File: tb/rfs_shaper_test.sv */
`timescale 1ns/1ps
`default_nettype none
module rfs_shaper_test;
	import rfs_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic tx_env = 1'b0;
	logic tx_last_sc = 1'b0;
	rfs_shp_type boost;
	rfs_shp_type dip;
	rfs_rx_in_type rx_in;
	rfs_rx_out_type rx_o;
	logic irq;
	logic send = 1'b0;
	rfs_rx_in_type ev = '0;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] ofs [3] = '{RFS_OVS_OFS, RFS_UNS_OFS, RFS_RXC_OFS};
	logic [31:0] msk [3] = '{RFS_OVS_MASK, RFS_UNS_MASK, RFS_RXC_MASK};
	always #50 clk_in = ~clk_in;
	rfs_shaper dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .tx_env_in(tx_env), .tx_last_sc_in(tx_last_sc),
		.boost_out(boost), .dip_out(dip), .rx_in(rx_in), .rx_out(rx_o), .irq_out(irq));
	rfs_card_model card (.clk_in(clk_in), .rst_n_in(rst_n_in), .send_in(send), .event_in(ev), .rx_out(rx_in));
	// ****************************************
	// tasks
	// ****************************************
	task automatic report_and_stop();
		if (mismatches == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(name, exp, r);
	endtask
	// raise the envelope and follow the selected pattern stream bit by bit
	task automatic shape(input logic sel, input logic [15:0] pat, input logic [3:0] len, input logic on);
		rfs_shp_type s;
		int n;
		@(posedge clk_in);
		tx_env <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			#1;
			s = sel ? dip : boost;
			n++;
		end while (s.active !== 1'b1 && n < 4);
		chk("pattern active", {31'h0, on}, {31'h0, s.active});
		for (int i = 0; on && i <= len; i++) begin
			chk("pattern bit", {31'h0, pat[15 - i]}, {31'h0, s.bit_val});
			@(posedge clk_in);
			#1;
			s = sel ? dip : boost;
		end
		chk("pattern end", 32'h0, {31'h0, s.active});
		@(posedge clk_in);
		tx_env <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask
	task automatic rx(input rfs_rx_in_type v);
		@(posedge clk_in);
		send <= 1'b1;
		ev <= v;
		@(posedge clk_in);
		send <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] d;
		logic e;
		rfs_rx_in_type v;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd_chk(ofs[i], 32'h0, "reset value");
			wr(ofs[i], 32'hFFFFFFFF);
			rd_chk(ofs[i], msk[i], "masked readback");
		end
		apb(1'b0, 8'h40, 32'h0, d, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped read", 32'h0, d);
		wr(RFS_OVS_OFS, {16'hA5C3, 11'h0, 4'h3, 1'b1});
		shape(1'b0, 16'hA5C3, 4'h3, 1'b1);
		wr(RFS_OVS_OFS, {16'h9E37, 11'h0, 4'hF, 1'b1});
		shape(1'b0, 16'h9E37, 4'hF, 1'b1);
		wr(RFS_OVS_OFS, {16'hFFFF, 11'h0, 4'h3, 1'b0});
		shape(1'b0, 16'hFFFF, 4'h3, 1'b0);
		wr(RFS_UNS_OFS, {16'h6B2D, 10'h0, 1'b0, 4'h5, 1'b1});
		shape(1'b1, 16'h6B2D, 4'h5, 1'b1);
		wr(RFS_UNS_OFS, {16'hC3A1, 10'h0, 1'b1, 4'h2, 1'b0});
		shape(1'b1, 16'hC3A1, 4'h2, 1'b0);
		tx_last_sc <= 1'b1;
		shape(1'b1, 16'hC3A1, 4'h2, 1'b1);
		tx_last_sc <= 1'b0;
		wr(RFS_UNS_OFS, {16'h0, 10'h0, 1'b0, 4'h5, 1'b0});
		shape(1'b1, 16'h0, 4'h5, 1'b0);
		wr(RFS_RXC_OFS, 32'h01000000);
		v = '0;
		v.collision = 1'b1;
		rx(v);
		chk("integrity error", 32'h1, {31'h0, rx_o.integrity_err});
		rd_chk(RFS_STS_OFS, 32'h4, "status");
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(RFS_MSK_OFS, 32'h4);
		@(posedge clk_in);
		#1;
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(RFS_STS_OFS, 32'h4);
		@(posedge clk_in);
		#1;
		chk("irq cleared", 32'h0, {31'h0, irq});
		for (int p = 0; p < 2; p++) begin
			wr(RFS_RXC_OFS, {8'h0, p[0], 23'h0});
			v = '0;
			v.collision = 1'b1;
			rx(v);
			v = '0;
			v.bit_valid = 1'b1;
			v.bit_val = 1'b1;
			rx(v);
			chk("bit after collision", {31'h0, p[0]}, {31'h0, rx_o.bit_val});
			v = '0;
			v.frame_end = 1'b1;
			rx(v);
			wr(RFS_RXC_OFS, {9'h0, p[0], 22'h0});
			v.crc_en = 1'b1;
			v.frame_short = 1'b1;
			rx(v);
			chk("short frame stored", {31'h0, p[0]}, {31'h0, rx_o.store});
			chk("short frame dropped", {31'h0, ~p[0]}, {31'h0, rx_o.drop});
			wr(RFS_RXC_OFS, {10'h0, p[0], 21'h0});
			v = '0;
			v.bit_valid = 1'b1;
			v.crc_byte = 1'b1;
			rx(v);
			chk("crc bit written", {31'h0, p[0]}, {31'h0, rx_o.bit_valid});
		end
		wr(RFS_RXC_OFS, 32'h08000000);
		v = '0;
		v.frame_end = 1'b1;
		v.frame_lt4 = 1'b1;
		rx(v);
		chk("short frame ignored", 32'h1, {31'h0, rx_o.drop});
		for (int m = 0; m < 5; m++) begin
			wr(RFS_RXC_OFS, (32'h1 << 28) | (m << 25));
			v = '0;
			v.parity_err = 1'b1;
			v.byte_done = 1'b1;
			v.byte_idx = (m == 2) ? RFS_BYTE3_IDX : RFS_BYTE4_IDX;
			rx(v);
			chk("disturb error", {31'h0, m > 1}, {31'h0, rx_o.emd_err});
			chk("parity error", {31'h0, m < 2}, {31'h0, rx_o.parity_err});
		end
		for (int x = 0; x < 2; x++) begin
			wr(RFS_RXC_OFS, x[0] ? 32'h66000000 : 32'h46000000);
			v = '0;
			v.parity_absent = 1'b1;
			v.byte_done = 1'b1;
			v.byte_idx = RFS_BYTE4_IDX;
			rx(v);
			chk("absent parity disturb", {31'h0, x[0]}, {31'h0, rx_o.emd_err});
		end
		wr(RFS_RXC_OFS, 32'hB6000000);
		v = '0;
		v.parity_err = 1'b1;
		v.byte_idx = RFS_BYTE4_IDX;
		rx(v);
		chk("deferred parity", 32'h0, {31'h0, rx_o.parity_err | rx_o.emd_err});
		v.parity_err = 1'b0;
		v.byte_done = 1'b1;
		rx(v);
		chk("judged at byte end", 32'h1, {31'h0, rx_o.emd_err});
		report_and_stop();
	end
endmodule
`default_nettype wire
